// *** chgsel_pkg.sv ***
package chgsel_pkg;
	// register byte addresses; printed offsets are not multiples of four, so index times four
	localparam logic [7:0]  status_index   = 8'h7D;
	localparam logic [7:0]  fault_index    = 8'h7E;
	localparam logic [7:0]  revision_index = 8'h7F;
	localparam logic [11:0] addr_status    = {2'h0, status_index, 2'h0};
	localparam logic [11:0] addr_fault     = {2'h0, fault_index, 2'h0};
	localparam logic [11:0] addr_revision  = {2'h0, revision_index, 2'h0};
	// own control registers
	localparam logic [11:0] addr_threshold = 12'h400;   // five words, temperature thresholds
	localparam logic [11:0] addr_current   = 12'h420;   // five words, band currents
	localparam logic [11:0] addr_voltage   = 12'h440;   // five words, band voltages in mV
	localparam logic [11:0] addr_temp      = 12'h460;   // measured temperature
	localparam logic [11:0] addr_target_i  = 12'h464;
	localparam logic [11:0] addr_target_v  = 12'h468;
	localparam logic [11:0] addr_prog_v    = 12'h46C;
	localparam logic [11:0] addr_ctrl      = 12'h470;   // bit0 charge disable
	localparam logic [11:0] addr_irq_stat  = 12'h474;
	localparam logic [11:0] addr_irq_mask  = 12'h478;
	localparam int          band_count     = 5;
	// charger voltage grid
	localparam logic [15:0] volt_offset_mv = 16'h0DB0;  // 3504 mV
	localparam logic [15:0] volt_step_mv   = 16'h0010;  // 16 mV
	localparam int          volt_step_log2 = 4;
	// field positions
	localparam int          src_msb        = 7;
	localparam int          phase_msb      = 5;
	localparam int          watchdog_bit   = 7;
	localparam int          boost_bit      = 6;
	localparam int          sysovp_bit     = 3;
	localparam int          profile_bit    = 2;
	// interrupt bits: bit1 charge fault, bit0 system overvoltage
	localparam int          irq_charge_bit = 1;
	localparam int          irq_bat_bit    = 0;
	localparam logic [1:0]  irq_mask_reset = 2'h0;
	localparam logic [7:0]  mirror_reset   = 8'h00;
	localparam logic [15:0] word_reset     = 16'h0000;
	// input source codes
	typedef enum logic [1:0] {
		src_unknown = 2'b00,
		src_usb     = 2'b01,
		src_adapter = 2'b10,
		src_otg     = 2'b11
	} chgsel_source_type;
	// charge phase codes
	typedef enum logic [1:0] {
		phase_idle = 2'b00,
		phase_pre  = 2'b01,
		phase_fast = 2'b10,
		phase_done = 2'b11
	} chgsel_phase_type;
	// charge fault cause codes
	typedef enum logic [1:0] {
		fault_none    = 2'b00,
		fault_input   = 2'b01,
		fault_thermal = 2'b10,
		fault_timer   = 2'b11
	} chgsel_fault_type;
endpackage : chgsel_pkg

// *** chgsel_top.sv ***
`timescale 1ns/1ps
// Functional notes
// - status bits 7:6 give input source
// - status bits 5:4 give charge phase
// - status bits 3..0 are single flags
// - fault bit7 watchdog, bit6 boost fault
// - fault bits 5:4 give charge fault cause
// - fault bit3 flags system overvoltage
// - thermistor field meaningless; bits 1:0 reset zero
// - revision: reserved, part id, profile, revision
// - profile flag: 0 window, 1 multi-band
// - voltage quantised to offset and step grid
// - charger gets quantised voltage, not raw
// - five thresholds with current and voltage
// - band n above Tn, top band above T4
// - at or below T0: zero, disable charge
// - pure step lookup, no interpolation
// - separate mask bits gate fault interrupts
module chgsel_top (
	input  wire logic        pclk,               // system clock, 250 MHz
	input  wire logic        presetn,            // async reset, active low
	input  wire logic        psel,               // apb select
	input  wire logic        penable,            // apb enable
	input  wire logic        pwrite,             // apb direction
	input  wire logic [11:0] paddr,              // apb byte address
	input  wire logic [31:0] pwdata,             // apb write data
	output logic      [31:0] prdata,             // apb read data
	output logic             pready,             // apb ready
	output logic             pslverr,            // apb error, unmapped address
	input  wire logic        charger_valid,      // pulse: charger bytes below are fresh
	input  wire logic [7:0]  charger_status,     // charger system status byte
	input  wire logic [7:0]  charger_fault,      // charger fault byte
	input  wire logic [7:0]  charger_revision,   // charger revision byte
	output logic      [15:0] programmed_charge_voltage, // quantised voltage to charger, mV
	output logic      [15:0] programmed_charge_current, // current to charger
	output logic             charge_disable,     // charge-disable control bit
	output logic             irq                 // level interrupt
);

	////////////////////////////////////////////////////////////////////////////////
	// storage

	logic [7:0]  charger_system_status_mirror;
	logic [7:0]  charger_fault_mirror;
	logic [7:0]  charger_revision_mirror;
	logic [15:0] threshold [chgsel_pkg::band_count];
	logic [15:0] band_current [chgsel_pkg::band_count];
	logic [15:0] band_voltage [chgsel_pkg::band_count];
	logic [15:0] temperature;
	logic [15:0] target_charge_current;
	logic [15:0] target_charge_voltage;
	logic [15:0] next_current;
	logic [15:0] next_voltage;
	logic [15:0] next_prog_v;
	logic        next_disable;
	logic [1:0]  irq_status;
	logic [1:0]  irq_mask;
	logic [1:0]  irq_event;
	logic [1:0]  prev_fault;
	logic        wr_en;
	logic        rd_en;
	logic        addr_ok;
	logic [31:0] next_rdata;
	logic [15:0] above_grid;

	////////////////////////////////////////////////////////////////////////////////
	// apb slave: zero wait states, answer in the access cycle

	assign pready  = 1'b1;
	assign wr_en   = psel & penable & pwrite;
	assign rd_en   = psel & penable & ~pwrite;

	// read mux and decode
	always_comb begin
		next_rdata = 32'h0000_0000;
		addr_ok    = 1'b1;
		unique case (paddr)
			chgsel_pkg::addr_status:   next_rdata = {24'h000000, charger_system_status_mirror};
			chgsel_pkg::addr_fault:    next_rdata = {24'h000000, charger_fault_mirror};
			chgsel_pkg::addr_revision: next_rdata = {24'h000000, charger_revision_mirror};
			chgsel_pkg::addr_temp:     next_rdata = {16'h0000, temperature};
			chgsel_pkg::addr_target_i: next_rdata = {16'h0000, target_charge_current};
			chgsel_pkg::addr_target_v: next_rdata = {16'h0000, target_charge_voltage};
			chgsel_pkg::addr_prog_v:   next_rdata = {16'h0000, programmed_charge_voltage};
			chgsel_pkg::addr_ctrl:     next_rdata = {31'h0, charge_disable};
			chgsel_pkg::addr_irq_stat: next_rdata = {30'h0, irq_status};
			chgsel_pkg::addr_irq_mask: next_rdata = {30'h0, irq_mask};
			default: begin
				addr_ok = 1'b0;
				for (int i = 0; i < chgsel_pkg::band_count; i++) begin
					if (paddr == chgsel_pkg::addr_threshold + 12'(4 * i)) begin
						next_rdata = {16'h0000, threshold[i]};
						addr_ok    = 1'b1;
					end
					if (paddr == chgsel_pkg::addr_current + 12'(4 * i)) begin
						next_rdata = {16'h0000, band_current[i]};
						addr_ok    = 1'b1;
					end
					if (paddr == chgsel_pkg::addr_voltage + 12'(4 * i)) begin
						next_rdata = {16'h0000, band_voltage[i]};
						addr_ok    = 1'b1;
					end
				end
			end
		endcase
	end

	// read data registered at the access edge would be late, so it is combinational
	// from flops; pslverr flags unmapped addresses
	assign prdata  = rd_en ? next_rdata : 32'h0000_0000;
	assign pslverr = psel & penable & ~addr_ok;

	////////////////////////////////////////////////////////////////////////////////
	// charger mirrors, refreshed only from the charger side

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			charger_system_status_mirror <= chgsel_pkg::mirror_reset;
			charger_fault_mirror         <= chgsel_pkg::mirror_reset;
			charger_revision_mirror      <= chgsel_pkg::mirror_reset;
		end else if (charger_valid) begin
			// bus writes never reach these, so the mirrors stay read-only
			charger_system_status_mirror <= charger_status;
			charger_fault_mirror         <= charger_fault;
			charger_revision_mirror      <= charger_revision;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// temperature profile table, one register set per band

	generate
		for (genvar b = 0; b < chgsel_pkg::band_count; b++) begin : g_band
			// each band holds threshold, current and voltage
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					threshold[b]    <= chgsel_pkg::word_reset;
					band_current[b] <= chgsel_pkg::word_reset;
					band_voltage[b] <= chgsel_pkg::word_reset;
				end else if (wr_en) begin
					if (paddr == chgsel_pkg::addr_threshold + 12'(4 * b))
						threshold[b] <= pwdata[15:0];
					if (paddr == chgsel_pkg::addr_current + 12'(4 * b))
						band_current[b] <= pwdata[15:0];
					if (paddr == chgsel_pkg::addr_voltage + 12'(4 * b))
						band_voltage[b] <= pwdata[15:0];
				end
			end
		end
	endgenerate

	// measured temperature and interrupt mask
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			temperature <= chgsel_pkg::word_reset;
			irq_mask    <= chgsel_pkg::irq_mask_reset;
		end else if (wr_en) begin
			if (paddr == chgsel_pkg::addr_temp)
				temperature <= pwdata[15:0];
			if (paddr == chgsel_pkg::addr_irq_mask)
				irq_mask <= pwdata[1:0];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// band selection: signed compare; thresholds assumed ascending

	always_comb begin
		next_current = chgsel_pkg::word_reset;
		next_voltage = chgsel_pkg::word_reset;
		next_disable = 1'b1;
		// highest band whose threshold lies below the temperature wins
		for (int i = 0; i < chgsel_pkg::band_count; i++) begin
			if ($signed(temperature) > $signed(threshold[i])) begin
				next_current = band_current[i]; // stored value, no blending
				next_voltage = band_voltage[i];
				next_disable = 1'b0;
			end
		end
		// nothing matched: at or below lowest threshold, current and voltage stay zero, disable stays set
	end

	// quantise down onto the charger grid; below the offset clamps to the offset
	always_comb begin
		above_grid  = (next_voltage > chgsel_pkg::volt_offset_mv) ?
			16'(next_voltage - chgsel_pkg::volt_offset_mv) : 16'h0000;
		next_prog_v = 16'(chgsel_pkg::volt_offset_mv +
			((above_grid >> chgsel_pkg::volt_step_log2) << chgsel_pkg::volt_step_log2));
		if (next_voltage == 16'h0000)
			next_prog_v = 16'h0000; // zero target means no charge, not the grid floor
	end

	// targets and programmed values registered once per cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			target_charge_current     <= chgsel_pkg::word_reset;
			target_charge_voltage     <= chgsel_pkg::word_reset;
			programmed_charge_voltage <= chgsel_pkg::word_reset;
			programmed_charge_current <= chgsel_pkg::word_reset;
			charge_disable            <= 1'b1;
		end else begin
			target_charge_current     <= next_current;
			target_charge_voltage     <= next_voltage;
			programmed_charge_voltage <= next_prog_v;  // charger never sees raw value
			programmed_charge_current <= next_current;
			charge_disable            <= next_disable;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// interrupts: rising edge of charge fault cause nonzero or system overvoltage

	assign irq_event[chgsel_pkg::irq_charge_bit] =
		(charger_fault_mirror[chgsel_pkg::phase_msb -: 2] != 2'b00) &
		~prev_fault[chgsel_pkg::irq_charge_bit];
	assign irq_event[chgsel_pkg::irq_bat_bit] =
		charger_fault_mirror[chgsel_pkg::sysovp_bit] & ~prev_fault[chgsel_pkg::irq_bat_bit];

	// sticky status, read clears; a same-cycle event wins over the clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_status <= 2'b00;
			prev_fault <= 2'b00;
		end else begin
			prev_fault <= {charger_fault_mirror[chgsel_pkg::phase_msb -: 2] != 2'b00,
				charger_fault_mirror[chgsel_pkg::sysovp_bit]};
			if (rd_en && paddr == chgsel_pkg::addr_irq_stat)
				irq_status <= irq_event;
			else
				irq_status <= irq_status | irq_event;
		end
	end

	// one mask bit per source
	assign irq = |(irq_status & irq_mask);

endmodule : chgsel_top

// *** chgsel_asserts.sv ***
`timescale 1ns/1ps
module chgsel_asserts (
	input wire logic        pclk,                      // clock
	input wire logic        presetn,                   // reset, low
	input wire logic        psel,                      // select
	input wire logic        penable,                   // enable
	input wire logic        pwrite,                    // direction
	input wire logic [11:0] paddr,                     // address
	input wire logic [31:0] prdata,                    // read data
	input wire logic        pslverr,                   // error
	input wire logic        charger_valid,             // fresh bytes
	input wire logic [7:0]  charger_status,            // status byte
	input wire logic [7:0]  charger_fault,             // fault byte
	input wire logic [7:0]  charger_revision,          // revision byte
	input wire logic [15:0] programmed_charge_voltage, // to charger
	input wire logic [15:0] programmed_charge_current, // to charger
	input wire logic        charge_disable,            // disable
	input wire logic        irq                        // interrupt
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// a read access, and a charger update seen by a read exactly three cycles after it
	sequence s_rd(a);
		psel && penable && !pwrite && paddr == a;
	endsequence
	sequence s_load_rd(a);
		charger_valid ##3 s_rd(a);
	endsequence
	chk_status_mirror: assert property (
		s_load_rd(12'h1F4) |-> prdata == {24'h0, $past(charger_status, 3)})
		else $error("status mirror wrong");
	chk_fault_mirror: assert property (
		s_load_rd(12'h1F8) |-> prdata == {24'h0, $past(charger_fault, 3)})
		else $error("fault mirror wrong");
	chk_revision_mirror: assert property (
		s_load_rd(12'h1FC) |-> prdata == {24'h0, $past(charger_revision, 3)})
		else $error("revision mirror wrong");
	chk_disable_zero: assert property (
		charge_disable |-> programmed_charge_voltage == 16'h0 && programmed_charge_current == 16'h0)
		else $error("disabled charge not zero");
	chk_reset_disable: assert property ($rose(presetn) |-> charge_disable)
		else $error("charge not disabled after reset");
	chk_volt_grid: assert property (programmed_charge_voltage != 16'h0 |->
		programmed_charge_voltage >= 16'h0DB0 &&
		((programmed_charge_voltage - 16'h0DB0) & 16'h000F) == 16'h0)
		else $error("voltage off grid");
	chk_irq_clear: assert property (
		s_rd(12'h474) and !charger_valid && !$past(charger_valid) |=> !irq)
		else $error("irq not cleared by read");
	chk_unmapped_err: assert property (s_rd(12'hFFC) |-> pslverr && prdata == 32'h0)
		else $error("unmapped read not refused");
endmodule : chgsel_asserts
////////////////////////////////////////////////////////////////////////////////
bind chgsel_top chgsel_asserts i_chgsel_asserts (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pslverr(pslverr),
	.charger_valid(charger_valid), .charger_status(charger_status),
	.charger_fault(charger_fault), .charger_revision(charger_revision),
	.programmed_charge_voltage(programmed_charge_voltage),
	.programmed_charge_current(programmed_charge_current),
	.charge_disable(charge_disable), .irq(irq));

// *** chgsel_charger_model.sv ***
`timescale 1ns/1ps
module chgsel_charger_model (
	input  wire logic pclk,     // clock
	output logic       valid,    // update strobe
	output logic [7:0] status,   // status byte
	output logic [7:0] fault,    // fault byte
	output logic [7:0] revision  // revision byte
);
	// idle bytes after an update are inverted so a stale value never passes as fresh
	initial begin
		valid = 1'b0;
		status = 8'h00;
		fault = 8'h00;
		revision = 8'h00;
	end
	////////////////////////////////////////////////////////////////////////
	// one-cycle update of all three bytes together
	task automatic send(input logic [7:0] s, input logic [7:0] f, input logic [7:0] r);
		@(posedge pclk);
		valid <= 1'b1;
		status <= s;
		fault <= f;
		revision <= r;
		@(posedge pclk);
		valid <= 1'b0;
		status <= ~s;
		fault <= ~f;
		revision <= ~r;
	endtask : send
endmodule : chgsel_charger_model

// *** chgsel_test.sv ***
`timescale 1ns/1ps
module chgsel_test;
	logic               pclk = 1'b0;
	logic               presetn = 1'b0;
	logic               psel = 1'b0;
	logic               penable = 1'b0;
	logic               pwrite = 1'b0;
	logic        [11:0] paddr = 12'h000;
	logic        [31:0] pwdata = 32'h0;
	logic        [31:0] prdata, rd;
	logic               pready, pslverr, cv, cd, irq, err;
	logic         [7:0] cs, cf, cr;
	logic        [15:0] pv, pc;
	logic signed [15:0] thr [5];
	logic        [15:0] cur [5], vlt [5];
	int                 mismatches = 0, num_checks = 0, cycles = 0;
	chgsel_top i_chgsel_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .charger_valid(cv), .charger_status(cs), .charger_fault(cf),
		.charger_revision(cr), .programmed_charge_voltage(pv), .programmed_charge_current(pc),
		.charge_disable(cd), .irq(irq));
	chgsel_charger_model i_chgsel_charger_model (.pclk(pclk), .valid(cv), .status(cs),
		.fault(cf), .revision(cr));
	// 250 MHz clock
	always #2 pclk = ~pclk;
	// hang guard, far above the few hundred cycles the run needs
	always @(posedge pclk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			mismatches++;
			end_of_test();
		end
	end
	////////////////////////////////////////////////////////////////////////
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	// one apb transfer, held until pready is seen high
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	function automatic logic [15:0] quant(input logic [15:0] v);
		if (v == 16'h0) return 16'h0;
		if (v < 16'h0DB0) return 16'h0DB0;
		return ((v - 16'h0DB0) & 16'hFFF0) + 16'h0DB0;
	endfunction : quant
	// highest band whose threshold lies below t, -1 for none
	function automatic int band(input logic signed [15:0] t);
		band = -1;
		for (int i = 0; i < 5; i++) if (t > thr[i]) band = i;
	endfunction : band
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : end_of_test
	////////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		logic        [7:0] m [3];
		logic signed [15:0] t;
		int b;
		void'($urandom(32'h6CF649F8));
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		repeat (2) @(posedge pclk);
		check("disable", {31'h0, cd}, 32'h1);
		apb(1'b0, 12'h1F8, 32'h0);
		check("fault reset", rd, 32'h0);
		apb(1'b0, 12'h478, 32'h0);
		check("mask reset", rd, 32'h0);
		// every source, phase and cause code; first read rotates over the mirrors
		for (int i = 0; i < 8; i++) begin
			m[0] = {2'(i), ~2'(i), 4'($urandom)};
			m[1] = {2'($urandom), 2'(i), 4'($urandom)};
			m[2] = 8'($urandom);
			i_chgsel_charger_model.send(m[0], m[1], m[2]);
			for (int k = 0; k < 3; k++) begin
				apb(1'b0, 12'h1F4 + 12'(4 * ((i + k) % 3)), 32'h0);
				check("mirror", rd, {24'h0, m[(i + k) % 3]});
			end
			apb(1'b1, 12'h1F4 + 12'(4 * (i % 3)), 32'hFFFFFFFF);
			apb(1'b0, 12'h1F4 + 12'(4 * (i % 3)), 32'h0);
			check("read-only mirror", rd, {24'h0, m[i % 3]});
		end
		// ascending thresholds, random bands, one voltage off the grid
		for (int i = 0; i < 5; i++) begin
			thr[i] = 16'(i * 20 - 10 + int'($urandom % 5));
			cur[i] = 16'($urandom);
			vlt[i] = (i == 2) ? 16'h0DCA : 16'(3000 + $urandom % 1500);
			apb(1'b1, 12'h400 + 12'(4 * i), {16'h0, thr[i]});
			apb(1'b1, 12'h420 + 12'(4 * i), {16'h0, cur[i]});
			apb(1'b1, 12'h440 + 12'(4 * i), {16'h0, vlt[i]});
		end
		// each threshold and one above it, below the lowest, far above the top
		for (int j = 0; j < 12; j++) begin
			t = (j < 10) ? thr[j / 2] + 16'(j % 2) : (j == 10) ? thr[0] - 16'h1 : 16'h7FFF;
			apb(1'b1, 12'h460, {16'h0, t});
			repeat (2) @(posedge pclk);
			b = band(t);
			check("voltage", {16'h0, pv}, {16'h0, b < 0 ? 16'h0 : quant(vlt[b])});
			check("current", {16'h0, pc}, {16'h0, b < 0 ? 16'h0 : cur[b]});
			check("disable", {31'h0, cd}, {31'h0, b < 0});
			apb(1'b0, 12'h468, 32'h0);
			check("target voltage", rd, {16'h0, b < 0 ? 16'h0 : vlt[b]});
		end
		// fault events with both unmasked, then the charge fault masked out
		apb(1'b0, 12'h474, 32'h0);
		apb(1'b1, 12'h478, 32'h3);
		for (int j = 0; j < 2; j++) begin
			i_chgsel_charger_model.send(8'h00, 8'h00, 8'h00);
			i_chgsel_charger_model.send(8'h00, j ? 8'h10 : 8'h18, 8'h00);
			repeat (2) @(posedge pclk);
			check("irq", {31'h0, irq}, {31'h0, j == 0});
			apb(1'b0, 12'h474, 32'h0);
			check("irq status", rd, j ? 32'h2 : 32'h3);
			@(posedge pclk);
			check("irq cleared", {31'h0, irq}, 32'h0);
			apb(1'b1, 12'h478, 32'h1);
		end
		apb(1'b0, 12'hFFC, 32'h0);
		check("unmapped error", {31'h0, err}, 32'h1);
		end_of_test();
	end
endmodule : chgsel_test
